// ---- common/dac_link_if.sv ----
/*
  Four-wire serial link between the host serial master and the DAC
  word loader. Holds only wires; both ends sample in their own clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic sdata;
  logic sel_n;
  logic load_latch_strobe_n;

  modport host (
    output sclk,
    output sdata,
    output sel_n,
    output load_latch_strobe_n
  );
  modport device (
    input sclk,
    input sdata,
    input sel_n,
    input load_latch_strobe_n
  );
endinterface
`default_nettype wire

// ---- common/dac_link_pkg.sv ----
/*
  Shared constants for the serial DAC word loader link: word size,
  link clock divider, buffer depth and the latch reset value.
  Assumes both ends are clocked by clk_sys at 250 MHz.
*/
package dac_link_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          CNT_W          = 5;
  localparam logic [15:0] LATCH_RESET    = 16'h0000;
  localparam logic [15:0] BIPOLAR_ZERO   = 16'h8000;
  localparam int          SYS_PERIOD_PS  = 4000;
  localparam int          LINK_PERIOD_PS = 128000;
  localparam int          HALF_CYCLES    = LINK_PERIOD_PS / (2 * SYS_PERIOD_PS);
  localparam int          DIV_W          = 5;
  localparam int          BUF_DEPTH      = 2;
endpackage

// ---- sim/dac_link_asserts.sv ----
/*
  Checker for the four wires between the serial master and the word loader.
  Assumes it is instantiated beside the interface and sees clk_sys and rst.
*/
`timescale 1ns/10ps
`default_nettype none
module dac_link_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sel_n,
  input wire logic load_latch_strobe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [4:0] rise_cnt_reg;
  logic [4:0] rise_cnt_next;
  logic       sclk_d_reg;
  logic       sel_d_reg;

  // Counts link clock rises in the open frame; a frame start clears it.
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    if (!sel_n && sel_d_reg) begin
      rise_cnt_next = 5'h00;
    end else if (sclk && !sclk_d_reg && !sel_n) begin
      rise_cnt_next = rise_cnt_reg + 5'h01;
    end
  end

  // Registers the count and the previous pin levels.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise_cnt_reg <= 5'h00;
      sclk_d_reg   <= 1'b0;
      sel_d_reg    <= 1'b1;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      sclk_d_reg   <= sclk;
      sel_d_reg    <= sel_n;
    end
  end

  property p_idle_clk_low;
    sel_n |-> !sclk;
  endproperty
  a_idle_clk_low: assert property (p_idle_clk_low) else $error("link clock high while deselected");
  property p_strobe_high_in_frame;
    !sel_n |-> load_latch_strobe_n;
  endproperty
  a_strobe_high_in_frame: assert property (p_strobe_high_in_frame) else $error("strobe low in frame");
  property p_strobe_falls_deselected;
    $fell(load_latch_strobe_n) |-> sel_n;
  endproperty
  a_strobe_falls_deselected: assert property (p_strobe_falls_deselected) else $error("strobe fell in frame");
  property p_data_stable_clk_high;
    sclk |-> $stable(sdata);
  endproperty
  a_data_stable_clk_high: assert property (p_data_stable_clk_high) else $error("data moved while clock high");
  property p_clk_high_time;
    $rose(sclk) |-> ##16 $fell(sclk);
  endproperty
  a_clk_high_time: assert property (p_clk_high_time) else $error("link clock high time wrong");
  property p_sixteen_rises;
    $rose(sel_n) |-> rise_cnt_reg == 5'h10;
  endproperty
  a_sixteen_rises: assert property (p_sixteen_rises) else $error("frame without sixteen clock rises");
  property p_lead_time;
    $fell(sel_n) |-> !sclk [*8];
  endproperty
  a_lead_time: assert property (p_lead_time) else $error("clock rose too soon after select");
  property p_load_after_frame;
    $rose(sel_n) |-> ##[0:17] !load_latch_strobe_n;
  endproperty
  a_load_after_frame: assert property (p_load_after_frame) else $error("no load strobe after frame");

  // Both load styles and plain shifting are seen at least once.
  c_load_now: cover property ($rose(sel_n) && !load_latch_strobe_n);
  c_load_later: cover property ($rose(sel_n) && load_latch_strobe_n);
  c_shift: cover property ($rose(sclk));
endmodule
`default_nettype wire

// ---- sim/tb_serial_dac_word_loader.sv ----
/*
  Bench: a master and a loader face each other on one link; a second
  loader is driven by the bench itself to send odd frames.
  Assumes the shared package and the link interface are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_serial_dac_word_loader;
  import dac_link_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] word_data = 16'h0000;
  logic        word_valid = 1'b0;
  logic        defer_load = 1'b0;
  logic        word_ready;
  logic        busy;
  logic [15:0] code_a;
  logic [15:0] code_b;
  logic        zero_a;
  logic        pend_a;
  logic        pend_b;
  logic [15:0] wire_sh;
  logic [15:0] sent_q[$];
  int          miscompares = 0;
  int          n_compared = 0;
  dac_link_if link_a ();
  dac_link_if link_b ();

  // Free running system clock.
  always #2 clk_sys = ~clk_sys;

  dac_serial_master dac_serial_master_inst (.clk_sys(clk_sys), .rst(rst), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready), .defer_load(defer_load), .busy(busy),
    .link(link_a));
  dac_word_loader dac_word_loader_inst (.clk_sys(clk_sys), .rst(rst), .link(link_a),
    .dac_code(code_a), .code_is_zero_bipolar(zero_a), .word_pending(pend_a));
  dac_word_loader dac_word_loader_fault_inst (.clk_sys(clk_sys), .rst(rst), .link(link_b),
    .dac_code(code_b), .code_is_zero_bipolar(), .word_pending(pend_b));
  dac_link_asserts dac_link_asserts_inst (.clk_sys(clk_sys), .rst(rst), .sclk(link_a.sclk),
    .sdata(link_a.sdata), .sel_n(link_a.sel_n), .load_latch_strobe_n(link_a.load_latch_strobe_n));

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Valid stays up between calls, so back-to-back words need no idle cycle.
  task automatic push(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk_sys);
    word_data = w;
    word_valid = 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (word_ready !== 1'b1 && n < 2000);
    if (word_ready !== 1'b1) miscompares++;
    sent_q.push_back(w);
  endtask

  task automatic settle();
    int n;
    n = 0;
    @(negedge clk_sys);
    word_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (busy !== 1'b0) miscompares++;
    repeat (24) @(negedge clk_sys);
  endtask

  // One bit on the bench link; data moves with the falling clock edge.
  task automatic bit_out(input logic b);
    link_b.sdata = b;
    #62.5 link_b.sclk = 1'b1;
    #62.5 link_b.sclk = 1'b0;
  endtask

  // A released data line shows the inverse level, never a stale copy.
  // Frames start a quarter nanosecond past a falling edge, so that no
  // link edge of the 125 ns clock ever meets a clk_sys edge.
  task automatic frame(input int nbits, input logic [31:0] v);
    @(negedge clk_sys);
    #0.25 link_b.sel_n = 1'b0;
    #62.5;
    for (int i = nbits - 1; i >= 0; i--) bit_out(v[i]);
    #62.5 link_b.sel_n = 1'b1;
    link_b.sdata = ~link_b.sdata;
    #250;
  endtask

  // Rebuilds each word seen on the wire and compares it with what was sent.
  always @(posedge link_a.sclk) if (!link_a.sel_n) wire_sh = {wire_sh[14:0], link_a.sdata};
  always @(posedge link_a.sel_n) begin
    if (!rst && sent_q.size() > 0) chk16("wire word", sent_q.pop_front(), wire_sh);
  end

  // Cuts a hung run short well past the expected length.
  initial begin
    #300000;
    miscompares++;
    give_verdict();
  end

  initial begin
    link_b.sel_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    link_b.load_latch_strobe_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk1("ready after reset", 1'b1, word_ready);
    chk1("busy after reset", 1'b0, busy);
    chk16("code a at reset", LATCH_RESET, code_a);
    chk16("code b at reset", LATCH_RESET, code_b);
    chk1("pending a at reset", 1'b0, pend_a);
    push(16'hA5C3);
    push(16'h1234);
    push(16'h8000);
    settle();
    chk16("code a", BIPOLAR_ZERO, code_a);
    chk1("zero flag", 1'b1, zero_a);
    defer_load = 1'b1;
    push(16'h7FFF);
    @(negedge clk_sys) word_valid = 1'b0;
    @(posedge link_a.sel_n);
    repeat (10) @(negedge clk_sys);
    chk1("pending a", 1'b1, pend_a);
    chk16("code a held", 16'h8000, code_a);
    settle();
    chk16("code a deferred", 16'h7FFF, code_a);
    chk1("pending a after load", 1'b0, pend_a);
    chk1("zero flag off", 1'b0, zero_a);
    frame(16, 32'h0000C3A5);
    chk16("code b full", 16'hC3A5, code_b);
    frame(20, 32'h000F1357);
    chk16("code b long", 16'h1357, code_b);
    frame(8, 32'h0000009B);
    chk16("code b short", 16'h579B, code_b);
    @(negedge clk_sys);
    #0.25;
    for (int i = 0; i < 17; i++) bit_out(1'b1);
    #250;
    chk16("code b deselected", 16'h579B, code_b);
    frame(8, 32'h00000000);
    chk16("code b padded", 16'h9B00, code_b);
    link_b.load_latch_strobe_n = 1'b1;
    frame(16, 32'h00004321);
    frame(16, 32'h00005555);
    frame(16, 32'h00006666);
    chk16("code b waiting", 16'h9B00, code_b);
    chk1("pending b", 1'b1, pend_b);
    link_b.load_latch_strobe_n = 1'b0;
    #500;
    chk16("code b drained", 16'h5555, code_b);
    chk1("pending b drained", 1'b0, pend_b);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- src/dac_serial_master.sv ----
/*
  Host end of the serial DAC link: takes 16-bit words through a
  valid/ready port, buffers two of them and sends each MSB first as
  one framed word, mode 0, with an optional deferred load strobe.
  Assumes a single clk_sys; the link clock is divided down from it.
*/
`timescale 1ns/10ps
`default_nettype none
module dac_serial_master
  import dac_link_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [15:0] word_data,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic        defer_load,
  output logic             busy,
  dac_link_if.host         link
);

  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, DESEL, STROBE} state_e;

  // Two-entry input buffer; word_ready drops when both entries are full.
  logic [15:0] buf_reg [BUF_DEPTH];
  logic [15:0] buf_next [BUF_DEPTH];
  logic        wp_reg, rp_reg, wp_next, rp_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic        take, pop;

  state_e           st_reg, st_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [CNT_W-1:0] bit_reg, bit_next;
  logic [15:0]      sh_reg, sh_next;
  logic             sclk_reg, sclk_next, sd_reg, sd_next, sel_reg, sel_next;
  logic             ld_reg, ld_next, rdy_reg, rdy_next, busy_reg, busy_next;
  logic             tick;

  // Link timing, frame sequencing and buffer bookkeeping.
  always_comb begin
    tick      = (div_reg == DIV_W'(HALF_CYCLES - 1));
    div_next  = tick ? '0 : div_reg + DIV_W'(1);
    st_next   = st_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    sclk_next = sclk_reg;
    sd_next   = sd_reg;
    sel_next  = sel_reg;
    ld_next   = ld_reg;
    pop       = 1'b0;
    take      = word_valid && rdy_reg;
    buf_next  = buf_reg;
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    if (take) begin
      buf_next[wp_reg] = word_data;
      wp_next = ~wp_reg;
    end
    if (tick) begin
      case (st_reg)
        IDLE: begin
          if (cnt_reg != 2'd0) begin
            pop      = 1'b1;
            rp_next  = ~rp_reg;
            sh_next  = buf_reg[rp_reg];
            sel_next = 1'b0;
            ld_next  = 1'b1;
            st_next  = SETUP;
          end
        end
        SETUP: begin
          sd_next  = sh_reg[15];
          sh_next  = {sh_reg[14:0], 1'b0};
          bit_next = CNT_W'(WORD_BITS);
          st_next  = LOW;
        end
        LOW: begin
          sclk_next = 1'b1;
          bit_next  = bit_reg - CNT_W'(1);
          st_next   = HIGH;
        end
        HIGH: begin
          sclk_next = 1'b0;
          if (bit_reg == '0) begin
            st_next = DESEL;
          end else begin
            sd_next = sh_reg[15];
            sh_next = {sh_reg[14:0], 1'b0};
            st_next = LOW;
          end
        end
        DESEL: begin
          sel_next = 1'b1;
          if (defer_load) begin
            st_next = STROBE;
          end else begin
            ld_next = 1'b0;
            st_next = IDLE;
          end
        end
        STROBE: begin
          ld_next = 1'b0;
          st_next = IDLE;
        end
        default: st_next = IDLE;
      endcase
    end
    cnt_next  = cnt_reg + 2'(take) - 2'(pop);
    rdy_next  = (cnt_next != 2'd2);
    busy_next = (st_next != IDLE) || (cnt_next != 2'd0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg   <= IDLE;
      div_reg  <= '0;
      bit_reg  <= '0;
      sh_reg   <= 16'h0000;
      sclk_reg <= 1'b0;
      sd_reg   <= 1'b0;
      sel_reg  <= 1'b1;
      ld_reg   <= 1'b0;
      wp_reg   <= 1'b0;
      rp_reg   <= 1'b0;
      cnt_reg  <= 2'd0;
      rdy_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      sclk_reg <= sclk_next;
      sd_reg   <= sd_next;
      sel_reg  <= sel_next;
      ld_reg   <= ld_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      cnt_reg  <= cnt_next;
      rdy_reg  <= rdy_next;
      busy_reg <= busy_next;
    end
  end

  // Buffer storage needs no reset; the count guards every read.
  always_ff @(posedge clk_sys) begin
    buf_reg <= buf_next;
  end

  assign word_ready               = rdy_reg;
  assign busy                     = busy_reg;
  assign link.sclk                = sclk_reg;
  assign link.sdata               = sd_reg;
  assign link.sel_n               = sel_reg;
  assign link.load_latch_strobe_n = ld_reg;

endmodule
`default_nettype wire

// ---- src/dac_word_loader.sv ----
/*
  Device end of the serial DAC link: samples the link pins in clk_sys,
  assembles 16-bit words MSB first, buffers completed frames in a
  two-entry buffer and moves them into the DAC latch on chip-select
  rise or on the load strobe.
  Assumes the link pins are asynchronous to clk_sys and that the link
  clock is well under a quarter of the clk_sys rate.
*/
// Summary of operation
// - DAC latch is all zero after reset.
// - Shift register is not cleared at reset.
// - Host sends sixteen bits on first load.
// - Extra bits leave only last sixteen kept.
// - Short frames keep leftover earlier bits.
// - Host pads short data with LSB zeros.
// - Sample data on rising link clock edges.
// - Words travel most significant bit first.
// - Latch updates at frame end or strobe.
// - Byte hosts hold select across both bytes.
// - Host data stable at rising clock edge.
// - SPI host uses polarity 0, phase 0.
// - Bipolar codes are offset binary, 8000h zero.
// - Accept data only while select is low.
// - Select rise copies shift register to latch.
// - High strobe defers load; low strobe immediate.
`timescale 1ns/10ps
`default_nettype none
module dac_word_loader
  import dac_link_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  dac_link_if.device       link,
  output logic [15:0]      dac_code,
  output logic             code_is_zero_bipolar,
  output logic             word_pending
);

  // Three-stage synchronisers; only stages two and three are examined.
  logic [2:0] sclk_sync_reg;
  logic [2:0] sdata_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [2:0] ld_sync_reg;
  logic [2:0] sclk_sync_next;
  logic [2:0] sdata_sync_next;
  logic [2:0] sel_sync_next;
  logic [2:0] ld_sync_next;

  always_comb begin
    sclk_sync_next  = {sclk_sync_reg[1:0], link.sclk};
    sdata_sync_next = {sdata_sync_reg[1:0], link.sdata};
    sel_sync_next   = {sel_sync_reg[1:0], link.sel_n};
    ld_sync_next    = {ld_sync_reg[1:0], link.load_latch_strobe_n};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_sync_reg  <= 3'h0;
      sdata_sync_reg <= 3'h0;
      sel_sync_reg   <= 3'h7;
      ld_sync_reg    <= 3'h7;
    end else begin
      sclk_sync_reg  <= sclk_sync_next;
      sdata_sync_reg <= sdata_sync_next;
      sel_sync_reg   <= sel_sync_next;
      ld_sync_reg    <= ld_sync_next;
    end
  end

  // A clock, select or strobe level is only believed once stages two and three agree.
  logic sclk_lvl_reg;
  logic sel_lvl_reg;
  logic ld_lvl_reg;
  logic sclk_lvl_next;
  logic sel_lvl_next;
  logic ld_lvl_next;
  logic sclk_rise;
  logic sel_rise;
  logic ld_fall;

  always_comb begin
    sclk_lvl_next = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2] : sclk_lvl_reg;
    sel_lvl_next  = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_lvl_reg;
    ld_lvl_next   = (ld_sync_reg[1] == ld_sync_reg[2]) ? ld_sync_reg[2] : ld_lvl_reg;
    sclk_rise     = sclk_lvl_next & ~sclk_lvl_reg;
    sel_rise      = sel_lvl_next & ~sel_lvl_reg;
    ld_fall       = ~ld_lvl_next & ld_lvl_reg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_lvl_reg <= 1'b0;
      sel_lvl_reg  <= 1'b1;
      ld_lvl_reg   <= 1'b1;
    end else begin
      sclk_lvl_reg <= sclk_lvl_next;
      sel_lvl_reg  <= sel_lvl_next;
      ld_lvl_reg   <= ld_lvl_next;
    end
  end

  // Shift register: no reset on purpose, its power-up content is unknown.
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic        data_bit;

  // No bit counter: frames of any length shift in, because a short frame
  // must still hand over the leftover bits of the earlier word.
  always_comb begin
    data_bit   = sdata_sync_reg[2];
    shift_next = shift_reg;
    if (!sel_lvl_reg && sclk_rise) begin
      shift_next = {shift_reg[14:0], data_bit};
    end
  end

  always_ff @(posedge clk_sys) begin
    shift_reg <= shift_next;
  end

  // Two-entry buffer between frame completion and latch update, so a
  // strobe-deferred load keeps one further frame that arrives meanwhile.
  logic [15:0] buf_mem_reg [BUF_DEPTH];
  logic [15:0] buf_mem_next [BUF_DEPTH];
  // A frame that meets two waiting entries is dropped, so a host that
  // defers loads must strobe before a third word follows.
  logic        wr_ptr_reg;
  logic        rd_ptr_reg;
  logic        wr_ptr_next;
  logic        rd_ptr_next;
  logic [1:0]  count_reg;
  logic [1:0]  count_next;
  logic        in_valid;
  logic        in_ready;
  logic        out_valid;
  logic        out_ready;

  always_comb begin
    // A frame is offered when select rises; partial frames still carry
    // the leftover bits of the previous word.
    in_valid     = sel_rise;
    in_ready     = (count_reg != 2'd2);
    out_valid    = (count_reg != 2'd0);
    out_ready    = ~ld_lvl_reg | ld_fall;
    buf_mem_next = buf_mem_reg;
    wr_ptr_next  = wr_ptr_reg;
    rd_ptr_next  = rd_ptr_reg;
    count_next   = count_reg;
    if (in_valid && in_ready) begin
      buf_mem_next[wr_ptr_reg] = shift_reg;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (out_valid && out_ready) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    count_next = count_reg + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    buf_mem_reg <= buf_mem_next;
  end

  // DAC latch and its status outputs.
  logic [15:0] latch_reg;
  logic [15:0] latch_next;
  logic        zero_reg;
  logic        zero_next;
  logic        pend_reg;
  logic        pend_next;

  always_comb begin
    latch_next = latch_reg;
    if (out_valid && out_ready) begin
      latch_next = buf_mem_reg[rd_ptr_reg];
    end
    zero_next = (latch_next == BIPOLAR_ZERO);
    pend_next = (count_next != 2'd0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_reg <= LATCH_RESET;
      zero_reg  <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      zero_reg  <= zero_next;
      pend_reg  <= pend_next;
    end
  end

  assign dac_code             = latch_reg;
  assign code_is_zero_bipolar = zero_reg;
  assign word_pending         = pend_reg;

endmodule
`default_nettype wire
